/* File: osc_ctrl_pkg.sv */
// Constants and types shared by the oscillator source control block.
// Assumes a 32-bit APB register bus with word-aligned offsets.
package osc_ctrl_pkg;

  // Register byte offsets
  localparam logic [7:0] SOURCE_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] TRIM_OFFSET        = 8'h04;
  localparam logic [7:0] CONFIG_OFFSET      = 8'h08;

  // Field positions in clock_source_status_control
  localparam int SEL_LSB      = 6;
  localparam int REQ_BIT      = 5;
  localparam int ENGAGED_BIT  = 4;
  localparam int RANGE_LSB    = 2;
  localparam int FREQ_LSB     = 0;

  // Field positions in the configuration register
  localparam int KEEP_BIT     = 0;
  localparam int OUT_EN_BIT   = 1;

  // Reset values
  localparam logic [1:0] SEL_RESET   = 2'h0;
  localparam logic [1:0] FREQ_RESET  = 2'h0;
  localparam logic [1:0] RANGE_RESET = 2'h0;
  localparam logic [7:0] TRIM_RESET  = 8'h80;

  // Rising edges of the external clock seen before switching
  localparam logic [1:0] EDGES_TO_SWITCH = 2'h2;

  // Clock source selector codes
  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'h0,
    SRC_EXT_CLK  = 2'h1,
    SRC_EXT_RC   = 2'h2,
    SRC_CRYSTAL  = 2'h3
  } source_t;

  // Internal frequency codes
  localparam logic [1:0] FREQ_4M0  = 2'h0;
  localparam logic [1:0] FREQ_8M0  = 2'h1;
  localparam logic [1:0] FREQ_12M8 = 2'h2;

  // Crystal amplifier range codes
  localparam logic [1:0] RANGE_8M_32M   = 2'h0;
  localparam logic [1:0] RANGE_1M_8M    = 2'h1;
  localparam logic [1:0] RANGE_32K_100K = 2'h2;

  // What the clock output pin carries
  typedef enum logic [1:0] {
    OUTPIN_RELEASED  = 2'h0,
    OUTPIN_AMPLIFIER = 2'h1,
    OUTPIN_FAST_CLK  = 2'h2
  } outpin_t;

  // Switch sequencer states
  typedef enum logic [1:0] {
    ST_INTERNAL,
    ST_WAIT_EDGES,
    ST_SWITCH,
    ST_EXTERNAL
  } switch_state_t;

endpackage

/* File: pin_edge_sync.sv */
// Two-flop synchroniser with a rising-edge pulse for a pin input.
// Assumes the pin is asynchronous to pclk and slower than pclk / 2.
`timescale 1ns/100ps
`default_nettype none
module pin_edge_sync (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and synchronised results
  input  wire logic pin,
  output logic      level,
  output logic      rise
);

  logic meta;
  logic sync;
  logic prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
    end
  end

  // Edge taken between second and third stage only
  assign level = sync;
  assign rise  = sync & ~prev;

endmodule
`default_nettype wire

/* File: osc_source_ctrl.sv */
// Oscillator source selection, switch sequencing, trim and pin control.
// Assumes an APB master on pclk; analog oscillators sit outside and obey the enables.
//
// Notes on behaviour
// R1: selector 00 internal, 01 external clock, 10 RC, 11 crystal.
// R2: after reset the bus clock comes from the internal oscillator.
// R3: frequency code 00 4.0 MHz, 01 8.0 MHz, 10 12.8 MHz; 11 reserved.
// R4: range code 00 8-32 MHz, 01 1-8 MHz, 10 32-100 kHz; 11 reserved.
// R5: external request enables the input pin and starts switching; reset clears it.
// R6: external request ignored in monitor mode with internal oscillator bypassed.
// R7: engaged bit reads 1 while an external source drives the clock.
// R8: each trim step changes the internal period by about 0.2 percent.
// R9: trim applies to the period of the selected internal frequency.
// R10: the block raises no interrupts.
// R11: no break-clearable flags; break state changes nothing.
// R12: in wait mode the oscillator keeps running and supplying both clocks.
// R13: in stop mode the oscillator runs only with keep-running-in-stop set; the code also keeps it running while stop_oscillator_enable is high.
// R14: input pin released in internal mode, claimed as clock input otherwise.
// R15: crystal mode gives the output pin to the inverting amplifier.
// R16: output pin released in internal, external clock or RC mode unless enabled.
// R17: output enable drives fast clock in internal or RC mode only.
// R18: wait two external rising edges, switch, set engaged, then stop internal.
// R19: clearing selector and request disengages and returns to internal oscillator.
// R20: fast clock equals the source; half-rate clock is that divided by two.
// R21: stop-mode enable from the integration unit gates the oscillator unless overridden.
// R22: 8-bit registers on the bus; unimplemented bits read zero, ignore writes.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module osc_source_ctrl (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr, // R10
  // Operating mode from the integration unit
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  input  wire logic        stop_oscillator_enable,
  input  wire logic        monitor_bypass,
  input  wire logic        break_state,
  // Clock input pin level
  input  wire logic        clock_input_pin,
  // Oscillator controls
  output logic             internal_osc_enable,
  output logic [1:0]       internal_frequency_code,
  output logic [7:0]       trim_factor,
  output logic             external_input_enable,
  output logic             rc_enable,
  output logic [2:0]       amplifier_enable,
  // Clock routing
  output logic             external_clock_engaged,
  output logic             fast_clock_from_external,
  output logic             half_rate_divide_enable,
  // Pin ownership
  output logic             clock_input_pin_claimed,
  output logic [1:0]       clock_output_pin_mode
);

  // Register state
  logic [1:0] clock_source_selector;
  logic       external_clock_request;
  logic [1:0] crystal_range_code;
  logic       keep_running_in_stop;
  logic       clock_output_pin_enable;
  logic       engaged;
  logic       internal_stopped;
  logic [1:0] edge_count;
  osc_ctrl_pkg::switch_state_t state;
  osc_ctrl_pkg::switch_state_t next_state;

  // Bus decode
  wire setup_phase  = psel & ~penable;
  wire access_phase = psel & penable;
  wire hit_source   = (paddr == osc_ctrl_pkg::SOURCE_CTRL_OFFSET);
  wire hit_trim     = (paddr == osc_ctrl_pkg::TRIM_OFFSET);
  wire hit_config   = (paddr == osc_ctrl_pkg::CONFIG_OFFSET);
  wire mapped       = hit_source | hit_trim | hit_config;
  wire wr_strobe    = access_phase & pwrite & mapped;

  // Single access cycle; read data captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access_phase & ~mapped;

  wire [7:0] source_view = {clock_source_selector, external_clock_request, engaged,
                            crystal_range_code, internal_frequency_code};
  wire [7:0] config_view = {6'h00, clock_output_pin_enable, keep_running_in_stop};
  wire [7:0] read_mux    = hit_source ? source_view :
                           hit_trim   ? trim_factor :
                           hit_config ? config_view : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
      prdata <= {24'h000000, read_mux}; // R22
    end
  end

  // Source register; engaged bit is not writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_source_selector   <= osc_ctrl_pkg::SEL_RESET; // R2
      external_clock_request  <= 1'b0; // R5
      crystal_range_code      <= osc_ctrl_pkg::RANGE_RESET;
      internal_frequency_code <= osc_ctrl_pkg::FREQ_RESET; // R3
    end else if (wr_strobe && hit_source) begin
      clock_source_selector   <= pwdata[osc_ctrl_pkg::SEL_LSB +: 2]; // R1
      external_clock_request  <= pwdata[osc_ctrl_pkg::REQ_BIT];
      crystal_range_code      <= pwdata[osc_ctrl_pkg::RANGE_LSB +: 2]; // R4
      internal_frequency_code <= pwdata[osc_ctrl_pkg::FREQ_LSB +: 2]; // R3
    end
  end

  // Trim goes straight to the oscillator, relative to the selected frequency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_factor <= osc_ctrl_pkg::TRIM_RESET;
    end else if (wr_strobe && hit_trim) begin
      trim_factor <= pwdata[7:0]; // R8 R9
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keep_running_in_stop    <= 1'b0;
      clock_output_pin_enable <= 1'b0;
    end else if (wr_strobe && hit_config) begin
      keep_running_in_stop    <= pwdata[osc_ctrl_pkg::KEEP_BIT];
      clock_output_pin_enable <= pwdata[osc_ctrl_pkg::OUT_EN_BIT];
    end
  end

  // External clock pin seen through two flops
  logic pin_level;
  logic pin_rise;

  pin_edge_sync u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (clock_input_pin),
    .level   (pin_level),
    .rise    (pin_rise)
  );

  // Switch sequencer
  wire effective_request = external_clock_request & ~monitor_bypass; // R6
  wire sel_internal      = (clock_source_selector == osc_ctrl_pkg::SRC_INTERNAL);
  wire release_request   = sel_internal & ~external_clock_request; // R19
  wire edges_seen        = pin_rise & (edge_count == osc_ctrl_pkg::EDGES_TO_SWITCH - 2'h1);

  always_comb begin
    next_state = state;
    case (state)
      osc_ctrl_pkg::ST_INTERNAL:
        if (effective_request && !sel_internal) begin
          next_state = osc_ctrl_pkg::ST_WAIT_EDGES; // R5
        end
      osc_ctrl_pkg::ST_WAIT_EDGES:
        if (!effective_request) begin
          next_state = osc_ctrl_pkg::ST_INTERNAL;
        end else if (edges_seen) begin
          next_state = osc_ctrl_pkg::ST_SWITCH; // R18
        end
      osc_ctrl_pkg::ST_SWITCH:
        next_state = osc_ctrl_pkg::ST_EXTERNAL; // R18
      osc_ctrl_pkg::ST_EXTERNAL:
        if (release_request) begin
          next_state = osc_ctrl_pkg::ST_INTERNAL; // R19
        end
      default:
        next_state = osc_ctrl_pkg::ST_INTERNAL;
    endcase
  end

  // Break state deliberately unused: nothing here is break-clearable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= osc_ctrl_pkg::ST_INTERNAL;
    end else begin
      state <= next_state; // R11
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_count <= 2'h0;
    end else if (state != osc_ctrl_pkg::ST_WAIT_EDGES) begin
      edge_count <= 2'h0;
    end else if (pin_rise) begin
      edge_count <= edge_count + 2'h1; // R18
    end
  end

  // Engaged is set one cycle before the internal oscillator is stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      engaged          <= 1'b0;
      internal_stopped <= 1'b0;
    end else begin
      engaged          <= (next_state == osc_ctrl_pkg::ST_SWITCH) |
                          (next_state == osc_ctrl_pkg::ST_EXTERNAL); // R7 R18
      internal_stopped <= (next_state == osc_ctrl_pkg::ST_EXTERNAL); // R18
    end
  end

  assign external_clock_engaged   = engaged; // R7
  assign fast_clock_from_external = engaged; // R2 R20

  // Stop mode gates all oscillators unless told to keep running; wait has no effect
  wire run_allowed = ~stop_mode | stop_oscillator_enable | keep_running_in_stop; // R12 R13 R21

  assign internal_osc_enable     = run_allowed & ~internal_stopped;
  assign half_rate_divide_enable = run_allowed; // R20
  assign external_input_enable   = run_allowed & ~sel_internal & effective_request; // R5
  assign rc_enable               = run_allowed &
                                   (clock_source_selector == osc_ctrl_pkg::SRC_EXT_RC);

  wire sel_crystal = (clock_source_selector == osc_ctrl_pkg::SRC_CRYSTAL);

  // One amplifier per range; reserved range code enables none
  genvar r;
  generate
    for (r = 0; r < 3; r++) begin : g_amp
      assign amplifier_enable[r] = run_allowed & sel_crystal &
                                   (crystal_range_code == 2'(r)); // R4
    end
  endgenerate

  // Pin ownership
  wire sel_ext_clk = (clock_source_selector == osc_ctrl_pkg::SRC_EXT_CLK);

  assign clock_input_pin_claimed = ~sel_internal; // R14
  assign clock_output_pin_mode =
    sel_crystal ? osc_ctrl_pkg::OUTPIN_AMPLIFIER : // R15
    (clock_output_pin_enable && !sel_ext_clk) ? osc_ctrl_pkg::OUTPIN_FAST_CLK : // R17
    osc_ctrl_pkg::OUTPIN_RELEASED; // R16

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence second_edge_s;
    state == osc_ctrl_pkg::ST_WAIT_EDGES && effective_request &&
    pin_rise && edge_count == 2'h1;
  endsequence

  sequence engage_s;
    engaged && !internal_stopped ##1 engaged && internal_stopped;
  endsequence

  engage_after_edges_a: assert property ( // R18
    $rose(engaged) |-> $past(pin_rise))
    else $error("engaged rose without an input edge");

  engage_order_a: assert property ( // R18
    $rose(engaged) |-> engage_s)
    else $error("internal oscillator stopped out of order");

  no_early_stop_a: assert property ( // R18
    internal_stopped |-> engaged)
    else $error("internal oscillator stopped while not engaged");

  bypass_ignores_a: assert property ( // R6
    (monitor_bypass && state == osc_ctrl_pkg::ST_INTERNAL) |=> state == osc_ctrl_pkg::ST_INTERNAL)
    else $error("request honoured under monitor bypass");

  release_return_a: assert property ( // R19
    (state == osc_ctrl_pkg::ST_EXTERNAL && release_request) |-> ##2 !engaged && !internal_stopped)
    else $error("no return to the internal oscillator");

  stop_gating_a: assert property ( // R13
    (stop_mode && !stop_oscillator_enable && !keep_running_in_stop)
      |-> !internal_osc_enable && amplifier_enable == 3'h0)
    else $error("oscillator running in stop without permission");

  wait_running_a: assert property ( // R12
    (wait_mode && !stop_mode && !internal_stopped) |-> internal_osc_enable)
    else $error("oscillator stopped in wait mode");

  crystal_pin_a: assert property ( // R15
    sel_crystal |-> clock_output_pin_mode == osc_ctrl_pkg::OUTPIN_AMPLIFIER)
    else $error("crystal mode did not claim the output pin");

  ext_clk_pin_a: assert property ( // R17
    sel_ext_clk |-> clock_output_pin_mode == osc_ctrl_pkg::OUTPIN_RELEASED)
    else $error("external clock mode drove the output pin");

  input_pin_a: assert property ( // R14
    clock_input_pin_claimed == (clock_source_selector != osc_ctrl_pkg::SRC_INTERNAL))
    else $error("input pin ownership wrong");

  read_engaged_a: assert property ( // R7
    (setup_phase && !pwrite && hit_source) |=> prdata[osc_ctrl_pkg::ENGAGED_BIT] == $past(engaged))
    else $error("engaged bit misreported");

  read_config_a: assert property ( // R22
    (setup_phase && !pwrite && hit_config) |=> prdata[31:2] == 30'h00000000)
    else $error("unimplemented bits read nonzero");

  break_neutral_a: assert property ( // R11
    (break_state && state == osc_ctrl_pkg::ST_EXTERNAL && !release_request) |=> engaged)
    else $error("break state disturbed the clock source");

  ext_input_gate_a: assert property ( // R5
    external_input_enable |-> external_clock_request && !monitor_bypass && !sel_internal)
    else $error("input pin enabled without a valid request");

  internal_outpin_a: assert property ( // R17
    (sel_internal && clock_output_pin_enable) |-> clock_output_pin_mode == osc_ctrl_pkg::OUTPIN_FAST_CLK)
    else $error("enabled output pin did not carry the fast clock");

  released_outpin_a: assert property ( // R16
    (!sel_crystal && !clock_output_pin_enable) |-> clock_output_pin_mode == osc_ctrl_pkg::OUTPIN_RELEASED)
    else $error("output pin not released");

  reserved_range_a: assert property ( // R4
    (crystal_range_code == 2'h3) |-> amplifier_enable == 3'h0)
    else $error("reserved range enabled an amplifier");

  drop_request_a: assert property ( // R5
    (state == osc_ctrl_pkg::ST_WAIT_EDGES && !effective_request) |=> state == osc_ctrl_pkg::ST_INTERNAL)
    else $error("dropped request did not return to internal");

  first_edge_a: assert property ( // R18
    (state == osc_ctrl_pkg::ST_WAIT_EDGES && edge_count == 2'h0) |=> state != osc_ctrl_pkg::ST_SWITCH)
    else $error("switched after a single input edge");

  switch_step_a: assert property ( // R18
    second_edge_s |=> state == osc_ctrl_pkg::ST_SWITCH ##1 state == osc_ctrl_pkg::ST_EXTERNAL)
    else $error("switch did not follow the second input edge");

  keep_in_stop_a: assert property ( // R13
    (stop_mode && keep_running_in_stop && !internal_stopped) |-> internal_osc_enable)
    else $error("oscillator stopped although told to keep running");

  engaged_state_a: assert property ( // R7
    engaged |-> state == osc_ctrl_pkg::ST_SWITCH || state == osc_ctrl_pkg::ST_EXTERNAL)
    else $error("engaged bit set outside the external states");

endmodule
`default_nettype wire

/* File: osc_ext_clock_model.sv */
// External clock source standing on the clock input pin.
// Assumes it is enabled by the block's input enable; free of pclk in phase.
`timescale 1ns/100ps
`default_nettype none
module osc_ext_clock_model #(
  parameter int HALF_NS = 170
) (
  // Enable from the block
  input  wire logic enable,
  // Pin level
  output var logic  pin
);
  initial pin = 1'b0;
  // Held still at low while not enabled, so no stray edges count
  always begin
    #(HALF_NS);
    if (enable) begin
      pin = ~pin;
    end else begin
      pin = 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: oscillator_source_select_control_tb_top.sv */
// Self-checking bench for the oscillator source control block.
// Assumes the APB slave answers with pready; one external clock model.
`timescale 1ns/100ps
`default_nettype none
module oscillator_source_select_control_tb_top;
  typedef struct {
    logic [7:0] src;
    logic [7:0] cfg;
    logic [7:0] rd;
    logic       claimed;
    logic [1:0] mode;
    logic [2:0] amp;
    logic       rc;
  } row_t;
  localparam logic [7:0] SRC = osc_ctrl_pkg::SOURCE_CTRL_OFFSET;
  localparam logic [7:0] TRM = osc_ctrl_pkg::TRIM_OFFSET;
  localparam logic [7:0] CFG = osc_ctrl_pkg::CONFIG_OFFSET;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, wait_mode = 1'b0, stop_mode = 1'b0, soe = 1'b0;
  logic mon = 1'b0, brk = 1'b0, pin, ioe, ext_en, rc_en, eng, fext, half, claimed;
  logic [1:0] freq, mode;
  logic [7:0] trim;
  logic [2:0] amp;
  int err_total = 0, checks_done = 0, rises = 0, n;
  row_t rows [9] = '{
    '{8'h11, 8'h02, 8'h01, 1'b0, 2'h2, 3'h0, 1'b0},
    '{8'h02, 8'h00, 8'h02, 1'b0, 2'h0, 3'h0, 1'b0},
    '{8'h40, 8'h02, 8'h40, 1'b1, 2'h0, 3'h0, 1'b0},
    '{8'h80, 8'h02, 8'h80, 1'b1, 2'h2, 3'h0, 1'b1},
    '{8'h80, 8'h00, 8'h80, 1'b1, 2'h0, 3'h0, 1'b1},
    '{8'hC0, 8'h00, 8'hC0, 1'b1, 2'h1, 3'h1, 1'b0},
    '{8'hC4, 8'h02, 8'hC4, 1'b1, 2'h1, 3'h2, 1'b0},
    '{8'hC8, 8'h00, 8'hC8, 1'b1, 2'h1, 3'h4, 1'b0},
    '{8'hCC, 8'h00, 8'hCC, 1'b1, 2'h1, 3'h0, 1'b0}};

  always #25 pclk = ~pclk;
  always @(posedge pin) rises++;

  osc_source_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .stop_oscillator_enable(soe), .monitor_bypass(mon), .break_state(brk),
    .clock_input_pin(pin), .internal_osc_enable(ioe), .internal_frequency_code(freq),
    .trim_factor(trim), .external_input_enable(ext_en), .rc_enable(rc_en),
    .amplifier_enable(amp), .external_clock_engaged(eng), .fast_clock_from_external(fext),
    .half_rate_divide_enable(half), .clock_input_pin_claimed(claimed),
    .clock_output_pin_mode(mode));
  osc_ext_clock_model i_src (.enable(ext_en), .pin(pin));

  task summarize;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer; the request stands until pready is seen high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 20) begin
      err_total++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task settle;
    @(posedge pclk);
    #1;
  endtask
  task wait_eng(input logic lvl, input int lim);
    n = 0;
    while (eng !== lvl && n < lim) begin
      settle();
      n++;
    end
    if (n >= lim) begin
      err_total++;
      summarize();
    end
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    check("ioe_rst", 32'h1, 32'(ioe));
    check("mode_rst", 32'h0, 32'(mode));
    apb(1'b0, SRC, 32'h0); check("src_rst", 32'h0, rd);
    apb(1'b0, TRM, 32'h0); check("trim_rst", 32'h80, rd);
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, CFG, {24'hFFFFFF, rows[i].cfg});
      apb(1'b1, SRC, {24'hFFFFFF, rows[i].src});
      apb(1'b0, SRC, 32'h0);
      check("src_rd", {24'h0, rows[i].rd}, rd);
      settle();
      check("claimed", 32'(rows[i].claimed), 32'(claimed));
      check("outpin", 32'(rows[i].mode), 32'(mode));
      check("amp", 32'(rows[i].amp), 32'(amp));
      check("rc", 32'(rows[i].rc), 32'(rc_en));
      check("freq", 32'(rows[i].src[1:0]), 32'(freq));
    end
    apb(1'b1, CFG, 32'hFF);
    apb(1'b0, CFG, 32'h0);
    check("cfg_rd", 32'h3, rd);
    apb(1'b1, TRM, 32'h7F); apb(1'b0, TRM, 32'h0);
    check("trim_rd", 32'h7F, rd);
    check("trim_pin", 32'h7F, 32'(trim));
    apb(1'b1, 8'h0C, 32'h55); apb(1'b0, 8'h0C, 32'h0);
    check("unmapped_rd", 32'h0, rd);
    check("unmapped_err", 32'h1, 32'(err));
    apb(1'b1, CFG, 32'h0); apb(1'b1, SRC, 32'h0);
    wait_mode <= 1'b1; settle();
    check("wait_run", 32'h3, {30'h0, ioe, half});
    @(posedge pclk);
    wait_mode <= 1'b0; stop_mode <= 1'b1; settle();
    check("stop_off", 32'h0, 32'(ioe));
    @(posedge pclk);
    soe <= 1'b1; settle();
    check("stop_soe", 32'h1, 32'(ioe));
    @(posedge pclk);
    soe <= 1'b0; apb(1'b1, CFG, 32'h1); settle();
    check("stop_keep", 32'h1, 32'(ioe));
    @(posedge pclk);
    stop_mode <= 1'b0; brk <= 1'b1;
    apb(1'b0, SRC, 32'h0); check("brk_src", 32'h0, rd);
    mon <= 1'b1;
    apb(1'b1, SRC, 32'h40); apb(1'b1, SRC, 32'h60);
    repeat (60) settle();
    check("mon_eng", 32'h0, 32'(eng));
    check("mon_in", 32'h0, 32'(ext_en));
    @(posedge pclk);
    rises = 0;
    mon <= 1'b0;
    wait_eng(1'b1, 200);
    check("rises", 32'h1, 32'(rises >= 2));
    check("ioe_hold", 32'h1, 32'(ioe));
    check("fext", 32'h1, 32'(fext));
    check("ext_in", 32'h1, 32'(ext_en));
    settle();
    check("ioe_stop", 32'h0, 32'(ioe));
    apb(1'b0, SRC, 32'h0); check("eng_rd", 32'h70, rd);
    apb(1'b1, SRC, 32'h0);
    wait_eng(1'b0, 4);
    settle();
    check("ioe_back", 32'h1, 32'(ioe));
    apb(1'b1, SRC, 32'h60);
    repeat (3) settle();
    apb(1'b1, SRC, 32'h40);
    settle();
    check("drop_in", 32'h0, 32'(ext_en));
    check("drop_eng", 32'h0, 32'(eng));
    apb(1'b1, SRC, 32'h60);
    repeat (5) settle();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) settle();
    check("eng_reset", 32'h0, 32'(eng));
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SRC, 32'h0); check("req_reset", 32'h0, rd);
    summarize();
  end
endmodule
`default_nettype wire
